// *** bench/ddr_mode_config_monitor.sv ***
// checker of mode loads, burst length four and read latencies two and three at the block ports
`default_nettype none
module ddr_mode_config_monitor
  import mode_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire mode_cfg_pkg::cmd_type cmd,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic col_valid,
  input wire logic col_is_write,
  input wire logic first_read_data,
  input wire logic [2:0] burst_len_code,
  input wire logic burst_interleaved,
  input wire logic [2:0] read_latency_code,
  input wire logic dll_reset_pulse,
  input wire logic dll_enabled,
  input wire logic reduced_drive
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // decoded loads and column commands
  wire logic base_ld = cmd == CMD_MODE_LOAD && !bank_select_high && !bank_select_low;
  wire logic ext_ld = cmd == CMD_MODE_LOAD && !bank_select_high && bank_select_low;
  wire logic col_cmd = cmd == CMD_READ || cmd == CMD_WRITE;
  sequence s_pulse; dll_reset_pulse ##1 !dll_reset_pulse; endsequence
  property p_base; base_ld |=> burst_len_code == $past(addr[2:0])
    && burst_interleaved == $past(addr[3]) && read_latency_code == $past(addr[6:4]); endproperty
  a_base: assert property (p_base) else $error("base fields wrong");
  property p_ext; ext_ld |=> dll_enabled == !$past(addr[0])
    && reduced_drive == $past(addr[1]); endproperty
  a_ext: assert property (p_ext) else $error("extended fields wrong");
  property p_dll; base_ld && addr[8] |=> s_pulse; endproperty
  a_dll: assert property (p_dll) else $error("no reset pulse");
  property p_sre; cmd == CMD_SELF_REFRESH_EXIT |=> dll_enabled; endproperty
  a_sre: assert property (p_sre) else $error("delay line off");
  property p_len4; col_cmd && burst_len_code == BL_CODE_4 |=> col_valid [*4]; endproperty
  a_len4: assert property (p_len4) else $error("burst too short");
  property p_wr; cmd == CMD_WRITE |=> col_is_write; endproperty
  a_wr: assert property (p_wr) else $error("write flag low");
  property p_cl3; cmd == CMD_READ && read_latency_code == CL_CODE_3 |-> ##2 first_read_data;
  endproperty
  a_cl3: assert property (p_cl3) else $error("latency three late");
  property p_cl2; cmd == CMD_READ && read_latency_code == CL_CODE_2 |-> ##1 first_read_data;
  endproperty
  a_cl2: assert property (p_cl2) else $error("latency two late");
endmodule : ddr_mode_config_monitor
bind ddr_mode_config ddr_mode_config_monitor u_mon (.*);
`default_nettype wire

// *** bench/ddr_mode_config_tb.sv ***
// self-checking bench for mode loads and burst column sequencing
`default_nettype none
module ddr_mode_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mode_cfg_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  cmd_type cmd;
  logic bank_select_low, bank_select_high, col_valid, col_is_write, first_read_data;
  logic burst_interleaved, dll_reset_pulse, dll_enabled, reduced_drive, base_loaded, ext_loaded;
  logic [ADDR_W-1:0] addr;
  logic [COL_W-1:0] col_addr;
  logic [2:0] burst_len_code, read_latency_code;
  int err_total = 0;
  int cmp_count = 0;
  ddr_mode_config u_dut (.*);
  mode_ctrl_model u_ctl (.*);
  always #20 clk = ~clk;
  // compare one value and report a mismatch
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // one burst from an odd start; columns, direction and first data per beat
  task automatic burst(input cmd_type c, input logic [2:0] bl, input logic bt,
      input logic [2:0] cl);
    logic [9:0] s, m, e;
    logic f;
    s = 10'h2F5;
    m = (10'h1 << bl) - 10'h1;
    u_ctl.load_base(bl, bt, cl, 1'b0);
    check({9'h0, burst_len_code, burst_interleaved, read_latency_code}, {9'h0, bl, bt, cl});
    u_ctl.issue(c, SEL_BASE, {3'h0, s});
    for (int i = 0; i <= m; i++) begin
      e = (s & ~m) | ((bt ? s ^ 10'(i) : s + 10'(i)) & m);
      f = c == CMD_READ && i == ((cl == CL_CODE_3) ? 1 : 0);
      check({3'h0, col_valid, col_is_write, first_read_data, col_addr},
          {4'h1, c == CMD_WRITE, f, e});
      @(negedge clk);
    end
    check({15'h0, col_valid}, 16'h0);
  endtask : burst
  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    check({13'h0, col_valid, base_loaded, ext_loaded}, 16'h0);
    for (int k = 1; k < 4; k++) begin
      burst(CMD_READ, 3'(k), 1'b0, k == 1 ? CL_CODE_25 : (k == 2 ? CL_CODE_2 : CL_CODE_3));
      burst(CMD_WRITE, 3'(k), 1'b1, CL_CODE_3);
    end
    u_ctl.load_ext(1'b1, 1'b1);
    check({14'h0, dll_enabled, reduced_drive}, 16'h1);
    u_ctl.issue(CMD_MODE_LOAD, 2'h3, 13'h0);
    u_ctl.issue(CMD_SELF_REFRESH_EXIT, 2'h0, 13'h0);
    check({14'h0, dll_enabled, reduced_drive}, 16'h3);
    u_ctl.load_ext(1'b0, 1'b0);
    check({12'h0, dll_enabled, reduced_drive, ext_loaded, base_loaded}, 16'hB);
    tally_and_finish();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end
endmodule : ddr_mode_config_tb
`default_nettype wire

// *** bench/mode_ctrl_model.sv ***
// controller model that issues mode loads and column commands
`default_nettype none
module mode_ctrl_model
  import mode_cfg_pkg::*;
(
  input wire logic clk,
  output var mode_cfg_pkg::cmd_type cmd,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic [ADDR_W-1:0] addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd = CMD_NOP;
    {bank_select_high, bank_select_low} = 2'h0;
    addr = ZERO_ADDR;
  end
  // one command for one edge, then the idle bus shows the inverse value
  task automatic issue(input cmd_type c, input logic [1:0] sel, input logic [12:0] a);
    @(negedge clk);
    cmd = c;
    {bank_select_high, bank_select_low} = sel;
    addr = a;
    @(negedge clk);
    cmd = CMD_NOP;
    addr = ~a;
    if (c == CMD_MODE_LOAD) repeat (2) @(negedge clk);
  endtask : issue
  // base load with undefined bits zero; a reset request gets a normal load after it
  task automatic load_base(input logic [2:0] bl, input logic bt, input logic [2:0] cl,
      input logic dll);
    issue(CMD_MODE_LOAD, SEL_BASE, {4'h0, dll, 1'b0, cl, bt, bl});
    if (dll) issue(CMD_MODE_LOAD, SEL_BASE, {6'h0, cl, bt, bl});
  endtask : load_base
  // enabling the delay line is followed by its reset and a long idle
  task automatic load_ext(input logic dis, input logic rd);
    issue(CMD_MODE_LOAD, SEL_EXT, {11'h0, rd, dis});
    if (!dis) begin
      load_base(BL_CODE_4, 1'b0, CL_CODE_3, 1'b1);
      repeat (200) @(negedge clk);
    end
  endtask : load_ext
endmodule : mode_ctrl_model
`default_nettype wire

// *** hw/burst_addr_gen.sv ***
// column address sequencing within an aligned burst block
`default_nettype none
module burst_addr_gen
  import mode_cfg_pkg::*;
#(
  parameter int COLW = COL_W
) (
  input wire logic [COLW-1:0] start_col,
  input wire logic [2:0] beat,
  input wire logic [2:0] len_mask,
  input wire logic interleave,
  input wire logic [3:0] top_bit,
  output logic [COLW-1:0] col
);
  logic [2:0] low;
  logic [COLW-1:0] top_mask;
  // low bits: offset plus or xor beat, kept within block
  always_comb begin
    if (interleave) begin
      low = (start_col[2:0] ^ beat) & len_mask;
    end else begin
      low = (start_col[2:0] + beat) & len_mask;
    end
    top_mask = COLW'((11'h002 << top_bit) - 11'h001);
    col = (start_col & top_mask & ~COLW'(len_mask)) | COLW'(low);
  end
endmodule : burst_addr_gen
`default_nettype wire

// *** hw/ddr_mode_config.sv ***
// mode and extended mode registers with burst sequencing
`default_nettype none
module ddr_mode_config
  import mode_cfg_pkg::*;
#(
  parameter mode_cfg_pkg::org_type ORG = mode_cfg_pkg::ORG_X8
) (
  input wire logic clk,
  input wire logic srst,
  input wire mode_cfg_pkg::cmd_type cmd,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [mode_cfg_pkg::ADDR_W-1:0] addr,
  output logic [mode_cfg_pkg::COL_W-1:0] col_addr,
  output logic col_valid,
  output logic col_is_write,
  output logic first_read_data,
  output logic [2:0] burst_len_code,
  output logic burst_interleaved,
  output logic [2:0] read_latency_code,
  output logic dll_reset_pulse,
  output logic dll_enabled,
  output logic reduced_drive,
  output logic base_loaded,
  output logic ext_loaded
);
  import mode_cfg_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] base_mode_config;
    logic [ADDR_W-1:0] extended_mode_config;
    logic base_ok;
    logic ext_ok;
    logic dll_rst;
    logic dll_on;
    logic active;
    logic wr;
    logic [COL_W-1:0] start;
    logic [2:0] beat;
  } state_type;
  state_type s_q, s_d;
  logic [2:0] len_mask;
  logic [3:0] top_bit;
  logic [COL_W-1:0] gen_col;
  logic [1:0] sel;
  // ****************************************
  // burst length decode
  // ****************************************
  function automatic logic [2:0] mask_of(input logic [2:0] code);
    case (code)
      BL_CODE_2: mask_of = 3'h1;
      BL_CODE_4: mask_of = 3'h3;
      BL_CODE_8: mask_of = 3'h7;
      default: mask_of = 3'h1;
    endcase
  endfunction : mask_of
  // one length for both directions
  assign len_mask = mask_of(s_q.base_mode_config[BL_HI:BL_LO]);
  assign top_bit = (ORG == ORG_X16) ? 4'(TOP_COL_X16) :
                   (ORG == ORG_X32) ? 4'(TOP_COL_X32) : 4'(TOP_COL_X8);
  assign sel = {bank_select_high, bank_select_low};
  // ****************************************
  // register loads and burst tracking
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.dll_rst = 1'b0;
    if (cmd == CMD_MODE_LOAD && sel == SEL_BASE) begin
      s_d.base_mode_config = addr;
      s_d.base_ok = 1'b1;
      s_d.dll_rst = addr[DLL_RST_BIT];
    end
    if (cmd == CMD_MODE_LOAD && sel == SEL_EXT) begin
      s_d.extended_mode_config = addr;
      s_d.ext_ok = 1'b1;
      s_d.dll_on = ~addr[DLL_DIS_BIT];
    end
    if (cmd == CMD_SELF_REFRESH_EXIT) begin
      s_d.dll_on = 1'b1;
      s_d.extended_mode_config[DLL_DIS_BIT] = 1'b0;
    end
    // advance beat, end after length beats
    if (s_q.active) begin
      s_d.beat = s_q.beat + 3'h1;
      if (s_q.beat == len_mask) begin
        s_d.active = 1'b0;
      end
    end
    if (cmd == CMD_READ || cmd == CMD_WRITE) begin
      s_d.active = 1'b1;
      s_d.wr = (cmd == CMD_WRITE);
      s_d.start = addr[COL_W-1:0];
      s_d.beat = 3'h0;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // ****************************************
  // column generation and read timing
  // ****************************************
  burst_addr_gen #(.COLW(COL_W)) u_gen (
    .start_col(s_q.start),
    .beat(s_q.beat),
    .len_mask(len_mask),
    .interleave(s_q.base_mode_config[BT_BIT]),
    .top_bit(top_bit),
    .col(gen_col)
  );
  read_latency_pipe u_lat (
    .clk(clk),
    .srst(srst),
    .read_cmd(cmd == CMD_READ),
    .cl_code(s_q.base_mode_config[CL_HI:CL_LO]),
    .first_data(first_read_data)
  );
  assign col_addr = gen_col;
  assign col_valid = s_q.active;
  assign col_is_write = s_q.wr;
  assign burst_len_code = s_q.base_mode_config[BL_HI:BL_LO];
  assign burst_interleaved = s_q.base_mode_config[BT_BIT];
  assign read_latency_code = s_q.base_mode_config[CL_HI:CL_LO];
  assign dll_reset_pulse = s_q.dll_rst;
  assign dll_enabled = s_q.dll_on;
  assign reduced_drive = s_q.extended_mode_config[DS_BIT];
  assign base_loaded = s_q.base_ok;
  assign ext_loaded = s_q.ext_ok;
endmodule : ddr_mode_config
`default_nettype wire

// *** hw/mode_cfg_pkg.sv ***
// constants and types shared by the mode configuration block
`default_nettype none
package mode_cfg_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 13;
  localparam int COL_W = 10;
  localparam int LAT_W = 3;
  // ****************************************
  // base register field positions
  // ****************************************
  localparam int BL_LO = 0;
  localparam int BL_HI = 2;
  localparam int BT_BIT = 3;
  localparam int CL_LO = 4;
  localparam int CL_HI = 6;
  localparam int OPMODE_BIT = 7;
  localparam int DLL_RST_BIT = 8;
  // ****************************************
  // extended register field positions
  // ****************************************
  localparam int DLL_DIS_BIT = 0;
  localparam int DS_BIT = 1;
  // ****************************************
  // field codes
  // ****************************************
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_CODE_2 = 3'h2;
  localparam logic [2:0] CL_CODE_3 = 3'h3;
  localparam logic [2:0] CL_CODE_25 = 3'h6;
  localparam logic [1:0] SEL_BASE = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h1;
  // ****************************************
  // organization and commands
  // ****************************************
  typedef enum logic [1:0] {ORG_X8, ORG_X16, ORG_X32} org_type;
  localparam int TOP_COL_X8 = 9;
  localparam int TOP_COL_X16 = 8;
  localparam int TOP_COL_X32 = 9;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_MODE_LOAD, CMD_READ, CMD_WRITE, CMD_SELF_REFRESH_EXIT
  } cmd_type;
  localparam logic [ADDR_W-1:0] ZERO_ADDR = 13'h0000;
endpackage : mode_cfg_pkg
`default_nettype wire

// *** hw/read_latency_pipe.sv ***
// read-data valid timing from programmed latency
`default_nettype none
module read_latency_pipe
  import mode_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic read_cmd,
  input wire logic [2:0] cl_code,
  output logic first_data
);
  typedef struct packed {
    logic [3:0] sr;
  } lat_state_type;
  lat_state_type s_q, s_d;
  // shift the read marker; tap by latency
  always_comb begin
    s_d = s_q;
    s_d.sr = {s_q.sr[2:0], read_cmd};
    case (cl_code)
      CL_CODE_3: first_data = s_q.sr[1];
      CL_CODE_2, CL_CODE_25: first_data = s_q.sr[0];
      default: first_data = s_q.sr[1];
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : read_latency_pipe
`default_nettype wire
